//--- tb/interrupt_priority_vector_unit_tb.sv
// Self-checking bench for the interrupt priority and vector unit
`default_nettype none
module interrupt_priority_vector_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h6736;
	logic pready, pslverr, pend, smo, mao, rvo, eco, ss, im, xm;
	logic [15:0] vec;
	logic ma = 0, mb = 1, ext_b = 1, ill = 0, swi = 0, rxs = 0, txe = 0, idl = 0, take = 0;
	logic nonmask_request_pin_b = 1, wd = 0, cf = 0, ovr = 0, txc = 0;
	logic [1:0] mcmd = 2'h3;
	logic [12:0] pf = 13'h0, pe = 13'h0;
	logic [7:0] rxd = 8'h0;
	int n_fail = 0, tests_run = 0, cyc = 0;
	always #10 clk = ~clk;
	ipv_top i_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .mode_pin_a_in(ma), .mode_pin_b_in(mb),
		.ext_req_b_in(ext_b), .nonmask_request_pin_b_in(nonmask_request_pin_b), .i_mask_in(im), .x_mask_in(xm),
		.illegal_op_in(ill), .swi_in(swi), .wdog_timeout_in(wd), .clock_fail_in(cf),
		.periph_flag_in(pf), .periph_en_in(pe), .rx_set_in(rxs), .rx_data_in(rxd),
		.overrun_in(ovr), .tx_empty_in(txe), .tx_done_in(txc), .idle_line_in(idl),
		.service_start_in(ss), .irq_pending_out(pend), .vector_out(vec),
		.special_mode_out(smo), .mode_a_out(mao), .read_vis_out(rvo), .eclk_drive_out(eco));
	ipv_cpu_model i_cpu (.clk_in(clk), .mask_cmd_in(mcmd), .take_in(take), .i_mask_out(im),
		.x_mask_out(xm), .service_start_out(ss));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task mask(input logic [1:0] m);
		mcmd <= m;
		repeat (3) @(posedge clk);
	endtask
	task serve(input logic [15:0] exp);
		repeat (4) @(posedge clk);
		take <= 1'b1;
		@(posedge clk);
		take <= 1'b0;
		repeat (3) @(posedge clk);
		chk(vec, exp);
		chk(pend, exp != 16'hFFFE);
	endtask
	task rst(input logic a, input logic b);
		ma <= a;
		mb <= b;
		rst_b <= 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [31:0] mode_reg(input logic a, input logic b);
		return {24'h0, !b & !a, !b, a, !b & a, 4'h6};
	endfunction
	function logic [15:0] exp_vec(input logic [14:0] act, input logic [3:0] c);
		int p;
		p = c > 7 ? c - 6 : c == 7 ? 1 : c > 4 ? 0 : c + 10;
		if (act[p]) return 16'hFFF2 - 16'(2 * p);
		for (int s = 0; s < 15; s++) if (act[s]) return 16'hFFF2 - 16'(2 * s);
		return 16'hFFFE;
	endfunction
	initial begin
		logic [31:0] ex;
		logic [14:0] act;
		for (int m = 3; m >= 0; m--) begin
			rst(m[0], !m[1]);
			ex = mode_reg(m[0], !m[1]);
			apb(0, 16'h103C, 0);
			chk(r, ex);
			chk(smo, m[1]);
			chk(mao, m[0]);
			chk(rvo, ex[4]);
			if (!m[0]) chk(eco, !ex[4]);
			mask(2'h2);
			apb(1, 16'h103C, {24'h0, 1'b1, ex[6:5], 1'b1, 4'h3});
			apb(0, 16'h103C, 0);
			chk(r, {24'h0, ex[6], ex[6:5], 1'b1, 4'h6});
			mask(2'h3);
			apb(1, 16'h103C, {24'h0, 1'b1, ex[6:5], 1'b1, 4'h3});
			apb(0, 16'h103C, 0);
			chk(r, {24'h0, ex[6], ex[6:5], 1'b1, 4'h3});
			if (!m[0]) chk(eco, 0);
			chk(rvo, ex[5]);
		end
		apb(0, 16'h1050, 0);
		chk(e, 1);
		chk(r, 0);
		apb(1, 16'h1040, 32'h29);
		for (int c = 0; c < 16; c++) begin
			mask(2'h3);
			apb(1, 16'h103C, 32'h10 + c);
			for (int k = 0; k < 4; k++) begin
				seed = lfsr(seed);
				pf <= seed[12:0];
				pe <= seed[25:13];
				ext_b <= seed[26];
				txe <= seed[27];
				idl <= seed[28];
				mcmd <= {1'b1, seed[29] & seed[30]};
				act = {seed[27] | seed[28], seed[12:0] & seed[25:13], !seed[26]};
				if (seed[29] & seed[30]) act = 15'h0;
				serve(exp_vec(act, c[3:0]));
			end
		end
		mask(2'h3);
		ill <= 1'b1;
		serve(16'hFFF8);
		ill <= 1'b0;
		swi <= 1'b1;
		serve(16'hFFF6);
		swi <= 1'b0;
		apb(1, 16'h1040, 32'h06);
		mask(2'h1);
		nonmask_request_pin_b <= 1'b0;
		ill <= 1'b1;
		serve(16'hFFF4);
		wd <= 1'b1;
		serve(16'hFFFA);
		cf <= 1'b1;
		serve(16'hFFFC);
		apb(1, 16'h1040, 32'h05);
		serve(16'hFFF4);
		{nonmask_request_pin_b, ill, wd, cf} <= 4'h8;
		pe <= 13'h0;
		ext_b <= 1'b1;
		mask(2'h2);
		ovr <= 1'b1;
		serve(16'hFFD6);
		ovr <= 1'b0;
		txc <= 1'b1;
		serve(16'hFFFE);
		apb(1, 16'h1040, 32'h15);
		serve(16'hFFD6);
		txc <= 1'b0;
		rxd <= 8'hA5 ^ seed[7:0];
		rxs <= 1'b1;
		@(posedge clk);
		rxs <= 1'b0;
		apb(0, 16'h1048, 0);
		chk(r, 32'h20);
		apb(0, 16'h104C, 0);
		chk(r, {24'h0, rxd});
		apb(0, 16'h1048, 0);
		chk(r, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire

//--- tb/ipv_chk.sv
// Port checker for the interrupt priority and vector unit
`default_nettype none
module ipv_chk (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic x_mask_in,
	input wire logic illegal_op_in,
	input wire logic swi_in,
	input wire logic wdog_timeout_in,
	input wire logic clock_fail_in,
	input wire logic service_start_in,
	input wire logic irq_pending_out,
	input wire logic [15:0] vector_out,
	input wire logic mode_a_out,
	input wire logic read_vis_out,
	input wire logic eclk_drive_out
);
	logic [2:0] up;
	// Mode outputs settle a few edges after release, so the gate check waits
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) up <= 3'h0;
		else if (up != 3'h7) up <= up + 3'h1;
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_wait;
		psel && penable && !pready ##1 pready;
	endsequence
	sequence s_calm;
		x_mask_in && $past(x_mask_in) && !wdog_timeout_in && !clock_fail_in && service_start_in;
	endsequence
	a_pready_one: assert property (pready |=> !pready) else $error("pready held");
	a_access_wait: assert property (psel && penable && !$past(penable) |-> s_wait)
		else $error("no single wait state");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
	a_vec_hold: assert property (!$past(service_start_in) |-> $stable(vector_out))
		else $error("vector moved");
	a_eclk_gate: assert property (up == 3'h7 && pready && !pwrite && !pslverr &&
		paddr == 16'h103C && !prdata[5] |-> eclk_drive_out == !prdata[4])
		else $error("eclk gate");
	a_vis_expanded: assert property (read_vis_out |-> mode_a_out)
		else $error("visibility outside expanded mode");
	a_trap_pend: assert property (illegal_op_in || swi_in |=> irq_pending_out)
		else $error("trap not pending");
	a_illegal_vec: assert property (s_calm ##0 illegal_op_in && $past(illegal_op_in)
		|=> vector_out == 16'hFFF8) else $error("illegal vector");
	a_swi_vec: assert property (s_calm ##0 swi_in && $past(swi_in) && !illegal_op_in &&
		!$past(illegal_op_in) |=> vector_out == 16'hFFF6) else $error("swi vector");
endmodule
bind ipv_top ipv_chk i_chk (.sys_clk_in, .rst_b_in, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready,
	.pslverr, .x_mask_in, .illegal_op_in, .swi_in, .wdog_timeout_in, .clock_fail_in,
	.service_start_in, .irq_pending_out, .vector_out, .mode_a_out, .read_vis_out,
	.eclk_drive_out);
`default_nettype wire

//--- tb/ipv_cpu_model.sv
// Behavioural CPU core: condition flag mask bits and the service-start strobe
`default_nettype none
module ipv_cpu_model (
	input wire logic clk_in,
	input wire logic [1:0] mask_cmd_in,
	input wire logic take_in,
	output var logic i_mask_out,
	output var logic x_mask_out,
	output var logic service_start_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		i_mask_out = 1'b1;
		x_mask_out = 1'b1;
		service_start_out = 1'b0;
	end
	// Masks only move on command, so each select write sees the mask level the bench chose before it
	always @(posedge clk_in) begin
		i_mask_out <= mask_cmd_in[0];
		x_mask_out <= mask_cmd_in[1];
		service_start_out <= take_in;
	end
endmodule
`default_nettype wire

//--- verilog/ipv_arbiter.v
// Maskable source arbitration with one promoted source
`include "ipv_map.vh"
`default_nettype none
module ipv_arbiter #(
	parameter NSRC = `IPV_NSRC
) (
	input wire [NSRC-1:0] req_in,
	input wire [3:0] psel_in,
	output reg valid_out,
	output reg [3:0] index_out
);
	// Map a select code to a source index; the reserved code falls back to the pin
	function [3:0] psel_to_index;
		input [3:0] code;
		begin
			case (code)
				4'h0: psel_to_index = `IPV_SRC_TOVF;
				4'h1: psel_to_index = `IPV_SRC_TOVF + 4'h1;
				4'h2: psel_to_index = `IPV_SRC_TOVF + 4'h2;
				4'h3: psel_to_index = `IPV_SRC_TOVF + 4'h3;
				4'h4: psel_to_index = `IPV_SRC_SER;
				4'h5: psel_to_index = `IPV_SRC_EXT;
				4'h6: psel_to_index = `IPV_SRC_EXT;
				4'h7: psel_to_index = `IPV_SRC_PER;
				default: psel_to_index = code - 4'h6;
			endcase
		end
	endfunction

	reg [3:0] promo;
	integer i;

	always @* begin
		promo = psel_to_index(psel_in);
		valid_out = 1'b0;
		index_out = 4'h0;
		// Scan from lowest priority so the highest pending one wins
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (req_in[i]) begin
				valid_out = 1'b1;
				index_out = i[3:0];
			end
		end
		// Promotion only reorders; a promoted source still needs its own request
		if (req_in[promo]) begin
			index_out = promo;
		end
	end
endmodule
`default_nettype wire

//--- verilog/ipv_map.vh
// Register map, field layout, reset values and vector table of the interrupt priority unit
`ifndef IPV_MAP_VH
`define IPV_MAP_VH

// APB byte addresses
`define IPV_ADDR_PRIO_MISC 16'h103C
`define IPV_ADDR_CTRL 16'h1040
`define IPV_ADDR_STATUS 16'h1044
`define IPV_ADDR_SER_STAT 16'h1048
`define IPV_ADDR_SER_DATA 16'h104C

// priority_and_mode_misc fields
`define IPV_BOOT_BIT 7
`define IPV_SPECIAL_MODE_BIT_BIT 6
`define IPV_MDA_BIT 5
`define IPV_RVIS_BIT 4
`define IPV_PSEL_HI 3
`define IPV_PSEL_LO 0
`define IPV_PSEL_RESET 4'h6
// Edges after internal reset release before the mode pins are captured
`define IPV_SETTLE_CNT 2'h2

// Control register fields
`define IPV_CTL_WDOG_DIS 0
`define IPV_CTL_CLK_FAIL_EN 1
`define IPV_CTL_RX_IE 2
`define IPV_CTL_TXE_IE 3
`define IPV_CTL_TXC_IE 4
`define IPV_CTL_IDLE_IE 5
`define IPV_CTL_WIDTH 6
`define IPV_CTL_RESET 6'h00

// Serial status fields as read back
`define IPV_SER_RXF 5
`define IPV_SER_OVR 3

// Maskable source indices in default priority order, 0 is highest
`define IPV_NSRC 15
`define IPV_SRC_EXT 4'h0
`define IPV_SRC_PER 4'h1
`define IPV_SRC_CAP1 4'h2
`define IPV_SRC_C4C5 4'h9
`define IPV_SRC_TOVF 4'hA
`define IPV_SRC_SER 4'hE

// Vector addresses
`define IPV_VEC_MASK_TOP 16'hFFF2
`define IPV_VEC_NONMASK_REQUEST_PIN 16'hFFF4
`define IPV_VEC_SWI 16'hFFF6
`define IPV_VEC_ILLEGAL 16'hFFF8
`define IPV_VEC_WDOG 16'hFFFA
`define IPV_VEC_CLKMON 16'hFFFC
`define IPV_VEC_RESET 16'hFFFE

`endif

//--- verilog/ipv_rx_flag.v
// Receive-full flag with status-then-data automatic clear
`default_nettype none
module ipv_rx_flag (
	input wire clk_in,
	input wire rst_b_in,
	input wire set_in,
	input wire status_rd_in,
	input wire data_rd_in,
	output wire flag_out
);
	reg flag_reg;
	reg armed_reg;

	assign flag_out = flag_reg;

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flag_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			// A new byte arriving in the clearing cycle keeps the flag set
			if (set_in) begin
				flag_reg <= 1'b1;
			end else if (data_rd_in && armed_reg) begin
				flag_reg <= 1'b0;
			end
			if (set_in || data_rd_in) begin
				armed_reg <= 1'b0;
			end else if (status_rd_in && flag_reg) begin
				armed_reg <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/ipv_top.v
// Interrupt priority and vector unit with mode and visibility register on APB
//
// Design decision made here: the APB register port.
`include "ipv_map.vh"
`default_nettype none
module ipv_top #(
	parameter NSRC = `IPV_NSRC
) (
	input wire sys_clk_in,
	input wire rst_b_in,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire mode_pin_a_in,
	input wire mode_pin_b_in,
	input wire ext_req_b_in,
	input wire nonmask_request_pin_b_in,
	input wire i_mask_in,
	input wire x_mask_in,
	input wire illegal_op_in,
	input wire swi_in,
	input wire wdog_timeout_in,
	input wire clock_fail_in,
	input wire [12:0] periph_flag_in,
	input wire [12:0] periph_en_in,
	input wire rx_set_in,
	input wire [7:0] rx_data_in,
	input wire overrun_in,
	input wire tx_empty_in,
	input wire tx_done_in,
	input wire idle_line_in,
	input wire service_start_in,
	output reg irq_pending_out,
	output reg [15:0] vector_out,
	output reg special_mode_out,
	output reg mode_a_out,
	output reg read_vis_out,
	output reg eclk_drive_out
);
	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_b;
	reg [1:0] mode_pin_a_sync_reg;
	reg [1:0] mode_pin_b_sync_reg;
	reg [1:0] ext_sync_reg;
	reg [1:0] nonmask_request_pin_sync_reg;
	reg captured_reg;
	reg [1:0] settle_reg;
	wire [4:0] addr_sel;
	localparam SEL_PRIO = 0;
	localparam SEL_CTRL = 1;
	localparam SEL_SSTAT = 3;
	localparam SEL_SDATA = 4;
	reg boot_rom_read_bit_reg;
	reg special_mode_bit_reg;
	reg mode_a_bit_reg;
	reg read_visibility_clock_out_reg;
	reg [3:0] psel_field_reg;
	reg [`IPV_CTL_WIDTH-1:0] ctrl_reg;
	wire [7:0] prio_misc_value;
	wire apb_done;
	wire wr_en;
	wire rd_en;
	wire rx_full_flag;
	wire ser_req;
	wire [NSRC-1:0] mask_req;
	wire arb_valid;
	wire [3:0] arb_index;
	reg [15:0] vec_next;
	reg any_next;
	reg hit;
	reg [31:0] rdata;

	// Reset released through two flops; assertion stays asynchronous
	always @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_b = rst_sync_reg;

	// Pins from outside pass two flops before any logic
	always @(posedge sys_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			mode_pin_a_sync_reg <= 2'b00;
			mode_pin_b_sync_reg <= 2'b00;
			ext_sync_reg <= 2'b11;
			nonmask_request_pin_sync_reg <= 2'b11;
		end else begin
			mode_pin_a_sync_reg <= {mode_pin_a_sync_reg[0], mode_pin_a_in};
			mode_pin_b_sync_reg <= {mode_pin_b_sync_reg[0], mode_pin_b_in};
			ext_sync_reg <= {ext_sync_reg[0], ext_req_b_in};
			nonmask_request_pin_sync_reg <= {nonmask_request_pin_sync_reg[0], nonmask_request_pin_b_in};
		end
	end

	// One-hot register select, shared by write strobes, flag clears and the error decode
	function [4:0] addr_decode;
		input [15:0] addr;
		begin
			case (addr)
				`IPV_ADDR_PRIO_MISC: addr_decode = 5'h01;
				`IPV_ADDR_CTRL: addr_decode = 5'h02;
				`IPV_ADDR_STATUS: addr_decode = 5'h04;
				`IPV_ADDR_SER_STAT: addr_decode = 5'h08;
				`IPV_ADDR_SER_DATA: addr_decode = 5'h10;
				default: addr_decode = 5'h00;
			endcase
		end
	endfunction

	assign addr_sel = addr_decode(paddr);

	// APB: one wait state, answer registered
	assign apb_done = psel && penable && pready;
	assign wr_en = apb_done && pwrite;
	assign rd_en = apb_done && !pwrite;

	// Synchronisers restart from their reset value, so capture waits until both stages refill
	always @(posedge sys_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			settle_reg <= 2'h0;
		end else if (settle_reg != `IPV_SETTLE_CNT) begin
			settle_reg <= settle_reg + 2'h1;
		end
	end

	// Mode pins are caught once the synchronisers hold settled post-reset levels
	always @(posedge sys_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			captured_reg <= 1'b0;
			boot_rom_read_bit_reg <= 1'b0;
			special_mode_bit_reg <= 1'b0;
			mode_a_bit_reg <= 1'b0;
			read_visibility_clock_out_reg <= 1'b0;
			psel_field_reg <= `IPV_PSEL_RESET;
			ctrl_reg <= `IPV_CTL_RESET;
		end else if (!captured_reg) begin
			// Writes are held off until the mode is known
			if (settle_reg == `IPV_SETTLE_CNT) begin
				captured_reg <= 1'b1;
				special_mode_bit_reg <= ~mode_pin_b_sync_reg[1];
				mode_a_bit_reg <= mode_pin_a_sync_reg[1];
				boot_rom_read_bit_reg <= ~mode_pin_b_sync_reg[1] & ~mode_pin_a_sync_reg[1];
				read_visibility_clock_out_reg <= ~mode_pin_b_sync_reg[1] & mode_pin_a_sync_reg[1];
			end
		end else if (wr_en && addr_sel[SEL_PRIO]) begin
			if (special_mode_bit_reg) begin
				boot_rom_read_bit_reg <= pwdata[`IPV_BOOT_BIT];
				special_mode_bit_reg <= pwdata[`IPV_SPECIAL_MODE_BIT_BIT];
				mode_a_bit_reg <= pwdata[`IPV_MDA_BIT];
			end else begin
				boot_rom_read_bit_reg <= 1'b0;
			end
			read_visibility_clock_out_reg <= pwdata[`IPV_RVIS_BIT];
			// Changing the order with interrupts live could race the arbitration
			if (i_mask_in) begin
				psel_field_reg <= pwdata[`IPV_PSEL_HI:`IPV_PSEL_LO];
			end
		end else if (wr_en && addr_sel[SEL_CTRL]) begin
			ctrl_reg <= pwdata[`IPV_CTL_WIDTH-1:0];
		end else if (!special_mode_bit_reg) begin
			boot_rom_read_bit_reg <= 1'b0;
		end
	end

	assign prio_misc_value = {boot_rom_read_bit_reg & special_mode_bit_reg,
		special_mode_bit_reg, mode_a_bit_reg, read_visibility_clock_out_reg,
		psel_field_reg};

	ipv_rx_flag u_rx_flag (
		.clk_in(sys_clk_in),
		.rst_b_in(rst_b),
		.set_in(rx_set_in),
		.status_rd_in(rd_en && addr_sel[SEL_SSTAT]),
		.data_rd_in(rd_en && addr_sel[SEL_SDATA]),
		.flag_out(rx_full_flag)
	);

	assign ser_req = ((rx_full_flag | overrun_in) & ctrl_reg[`IPV_CTL_RX_IE]) |
		(tx_empty_in & ctrl_reg[`IPV_CTL_TXE_IE]) |
		(tx_done_in & ctrl_reg[`IPV_CTL_TXC_IE]) |
		(idle_line_in & ctrl_reg[`IPV_CTL_IDLE_IE]);

	// Slot 0 is the pin, 1..13 the peripherals, 14 the serial group
	assign mask_req[`IPV_SRC_EXT] = ~ext_sync_reg[1] & ~i_mask_in;
	genvar g;
	generate
		for (g = 1; g < NSRC - 1; g = g + 1) begin : gen_mreq
			assign mask_req[g] = periph_flag_in[g-1] & periph_en_in[g-1] & ~i_mask_in;
		end
	endgenerate
	assign mask_req[`IPV_SRC_SER] = ser_req & ~i_mask_in;

	ipv_arbiter #(
		.NSRC(NSRC)
	) u_arbiter (
		.req_in(mask_req),
		.psel_in(psel_field_reg),
		.valid_out(arb_valid),
		.index_out(arb_index)
	);

	// Vector table: fixed per source, independent of promotion
	always @* begin
		any_next = 1'b1;
		if (clock_fail_in && ctrl_reg[`IPV_CTL_CLK_FAIL_EN]) begin
			vec_next = `IPV_VEC_CLKMON;
		end else if (wdog_timeout_in && !ctrl_reg[`IPV_CTL_WDOG_DIS]) begin
			vec_next = `IPV_VEC_WDOG;
		end else if (!nonmask_request_pin_sync_reg[1] && !x_mask_in) begin
			vec_next = `IPV_VEC_NONMASK_REQUEST_PIN;
		end else if (illegal_op_in) begin
			vec_next = `IPV_VEC_ILLEGAL;
		end else if (swi_in) begin
			vec_next = `IPV_VEC_SWI;
		end else if (arb_valid) begin
			vec_next = `IPV_VEC_MASK_TOP - {11'h000, arb_index, 1'b0};
		end else begin
			any_next = 1'b0;
			vec_next = `IPV_VEC_RESET;
		end
	end

	// Vector is latched at service start so a late arrival cannot move it mid-fetch
	always @(posedge sys_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			irq_pending_out <= 1'b0;
			vector_out <= `IPV_VEC_RESET;
		end else begin
			irq_pending_out <= any_next & captured_reg;
			if (service_start_in) begin
				vector_out <= vec_next;
			end
		end
	end

	// Expanded modes: visibility; single-chip and bootstrap: E clock gate
	always @(posedge sys_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			special_mode_out <= 1'b0;
			mode_a_out <= 1'b0;
			read_vis_out <= 1'b0;
			eclk_drive_out <= 1'b0;
		end else begin
			special_mode_out <= special_mode_bit_reg;
			mode_a_out <= mode_a_bit_reg;
			read_vis_out <= mode_a_bit_reg & read_visibility_clock_out_reg;
			eclk_drive_out <= mode_a_bit_reg | ~read_visibility_clock_out_reg;
		end
	end

	always @* begin
		hit = |addr_sel;
		rdata = 32'h0000_0000;
		case (paddr)
			`IPV_ADDR_PRIO_MISC: rdata = {24'h000000, prio_misc_value};
			`IPV_ADDR_CTRL: rdata = {26'h0000000, ctrl_reg};
			`IPV_ADDR_STATUS: rdata = {15'h0000, any_next, vec_next};
			`IPV_ADDR_SER_STAT: rdata = {24'h000000, 2'b00, rx_full_flag, 1'b0,
				overrun_in, 3'b000};
			`IPV_ADDR_SER_DATA: rdata = {24'h000000, rx_data_in};
			default: rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				pslverr <= ~hit;
				prdata <= pwrite ? 32'h0000_0000 : rdata;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire
